// ### ccr_pkg.sv
package ccr_pkg;

  localparam int ADDR_W = 12;

  localparam logic [11:0] ADDR_SERIAL_CFG = 12'h000;
  localparam logic [11:0] ADDR_READBACK = 12'h004;
  localparam logic [11:0] ADDR_VER_LO = 12'h005;
  localparam logic [11:0] ADDR_VER_HI = 12'h006;
  localparam logic [11:0] ADDR_PRI_LO = 12'h010;
  localparam logic [11:0] ADDR_PRI_HI = 12'h011;
  localparam logic [11:0] ADDR_SEC_LO = 12'h012;
  localparam logic [11:0] ADDR_SEC_HI = 12'h013;
  localparam logic [11:0] ADDR_TEST_DIV = 12'h014;

  // Serial port configuration bit positions, each function held in a mirrored pair; the readback control bit last
  localparam int BIT_SDO_A = 7;
  localparam int BIT_LSB_A = 6;
  localparam int BIT_SRST_A = 5;
  localparam int BIT_SRST_B = 2;
  localparam int BIT_LSB_B = 1;
  localparam int BIT_SDO_B = 0;
  localparam int BIT_READBACK = 0;

  localparam logic [7:0] RST_SERIAL_CFG = 8'h00;
  localparam logic [7:0] RST_READBACK = 8'h00;
  localparam logic [15:0] RST_VERSION = 16'h0000;
  localparam logic [9:0] RST_REF_DIV = 10'h000;
  localparam logic [5:0] RST_TEST_DIV = 6'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Staged settings; the active copy is loaded on an update strobe
  typedef struct packed {
    logic [15:0] version;
    logic [9:0] pri_div;
    logic [9:0] sec_div;
    logic [5:0] test_div;
  } ccr_set_t;

  typedef struct packed {
    ccr_set_t stage;
    ccr_set_t active;
    logic sdo_active;
    logic lsb_first;
    logic soft_rst;
    logic readback;
    logic [7:0] rdata;
    logic rd_valid;
  } ccr_state_t;

  localparam ccr_set_t SET_RESET = '{
    version: RST_VERSION, pri_div: RST_REF_DIV, sec_div: RST_REF_DIV, test_div: RST_TEST_DIV};

endpackage

// ### ccr_regs.sv
`timescale 1ns/1ps
module ccr_regs
  import ccr_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic i2c_mode, // Serial port is in I2C mode
  input wire logic wr_en, // Register write strobe
  input wire logic rd_en, // Register read strobe
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic io_update, // Copy staged settings to active
  output logic [7:0] rdata, // Read data, valid with rd_valid
  output logic rd_valid, // Read answer, one cycle
  output logic soft_reset, // Soft reset pulse, one cycle
  output logic sdo_active, // Serial data output enabled
  output logic lsb_first, // LSB first with ascending addresses
  output logic [15:0] customer_version, // Active customer version word
  output logic [9:0] primary_reference_div, // Active primary reference divider
  output logic [9:0] secondary_reference_div, // Active secondary reference divider
  output logic [5:0] test_ref_div // Active test divider
);

  ccr_state_t state_q;
  ccr_state_t state_d;
  logic addr_hit;
  logic [7:0] cfg_rd;

  localparam ccr_state_t STATE_RESET = '{
    stage: SET_RESET, active: SET_RESET,
    sdo_active: RST_SERIAL_CFG[BIT_SDO_B], lsb_first: RST_SERIAL_CFG[BIT_LSB_B],
    soft_rst: RST_SERIAL_CFG[BIT_SRST_B], readback: RST_READBACK[BIT_READBACK],
    rdata: READ_UNMAPPED, rd_valid: 1'b0};

  always_comb begin
    unique case (addr)
      ADDR_SERIAL_CFG, ADDR_READBACK, ADDR_VER_LO, ADDR_VER_HI, ADDR_PRI_LO,
      ADDR_PRI_HI, ADDR_SEC_LO, ADDR_SEC_HI, ADDR_TEST_DIV: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    cfg_rd = 8'h00;
    cfg_rd[BIT_SDO_A] = state_q.sdo_active;
    cfg_rd[BIT_SDO_B] = state_q.sdo_active;
    cfg_rd[BIT_LSB_A] = state_q.lsb_first;
    cfg_rd[BIT_LSB_B] = state_q.lsb_first;
  end

  // Reads follow the staged copy unless readback points at the active copy
  function automatic logic [7:0] read_mux(input logic [11:0] a, input ccr_set_t s,
                                          input logic [7:0] cfg, input logic rb);
    logic [7:0] r;
    r = READ_UNMAPPED;
    unique case (a)
      ADDR_SERIAL_CFG: r = cfg;
      ADDR_READBACK: r = {7'h00, rb};
      ADDR_VER_LO: r = s.version[7:0];
      ADDR_VER_HI: r = s.version[15:8];
      ADDR_PRI_LO: r = s.pri_div[7:0];
      ADDR_PRI_HI: r = {6'h00, s.pri_div[9:8]};
      ADDR_SEC_LO: r = s.sec_div[7:0];
      ADDR_SEC_HI: r = {6'h00, s.sec_div[9:8]};
      ADDR_TEST_DIV: r = {2'h0, s.test_div};
      default: r = READ_UNMAPPED;
    endcase
    return r;
  endfunction

  always_comb begin
    state_d = state_q;
    state_d.rd_valid = rd_en;
    if (rd_en) begin
      state_d.rdata = read_mux(addr, state_q.readback ? state_q.active : state_q.stage,
                               cfg_rd, state_q.readback);
    end
    if (io_update) begin
      state_d.active = state_q.stage;
    end
    if (wr_en && addr_hit) begin
      unique case (addr)
        ADDR_SERIAL_CFG: begin
          // Either half of a mirrored pair sets the function, so bit order never matters
          state_d.soft_rst = wdata[BIT_SRST_A] | wdata[BIT_SRST_B];
          if (!i2c_mode) begin
            state_d.sdo_active = wdata[BIT_SDO_A] | wdata[BIT_SDO_B];
            state_d.lsb_first = wdata[BIT_LSB_A] | wdata[BIT_LSB_B];
          end
        end
        ADDR_READBACK: state_d.readback = wdata[BIT_READBACK];
        ADDR_VER_LO: state_d.stage.version[7:0] = wdata;
        ADDR_VER_HI: state_d.stage.version[15:8] = wdata;
        ADDR_PRI_LO: state_d.stage.pri_div[7:0] = wdata;
        ADDR_PRI_HI: state_d.stage.pri_div[9:8] = wdata[1:0];
        ADDR_SEC_LO: state_d.stage.sec_div[7:0] = wdata;
        ADDR_SEC_HI: state_d.stage.sec_div[9:8] = wdata[1:0];
        ADDR_TEST_DIV: state_d.stage.test_div = wdata[5:0];
        default: state_d = state_d;
      endcase
    end
    // Soft reset returns every setting to default and clears itself
    if (state_q.soft_rst) begin
      state_d = STATE_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign rd_valid = state_q.rd_valid;
  assign soft_reset = state_q.soft_rst;
  assign sdo_active = state_q.sdo_active;
  assign lsb_first = state_q.lsb_first;
  assign customer_version = state_q.active.version;
  assign primary_reference_div = state_q.active.pri_div;
  assign secondary_reference_div = state_q.active.sec_div;
  assign test_ref_div = state_q.active.test_div;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Read valid is left out: it still follows whatever read strobe came the cycle before
  a_unmapped_write: assert property (
    wr_en && !addr_hit && !rd_en && !io_update && !state_q.soft_rst
    |=> $stable({state_q.stage, state_q.active, state_q.sdo_active, state_q.lsb_first,
    state_q.soft_rst, state_q.readback, state_q.rdata}))
    else $error("unmapped write changed state");
  a_readback_bit: assert property (
    wr_en && addr == ADDR_READBACK && !state_q.soft_rst ##1 !wr_en
    ##1 rd_en && addr == ADDR_READBACK |=> rdata == {7'h00, $past(wdata[BIT_READBACK], 3)})
    else $error("readback control bit not read back");
  a_readback_active: assert property (
    rd_en && addr == ADDR_VER_LO && state_q.readback && !state_q.soft_rst
    |=> rd_valid && rdata == $past(state_q.active.version[7:0]))
    else $error("active copy not selected for read");
  a_version_high: assert property (
    wr_en && addr == ADDR_VER_HI && !state_q.soft_rst ##1 !wr_en ##1 io_update
    |=> customer_version[15:8] == $past(wdata, 3))
    else $error("customer version high byte wrong");
  a_primary_high: assert property (
    wr_en && addr == ADDR_PRI_HI && !state_q.soft_rst
    |=> state_q.stage.pri_div[9:8] == $past(wdata[1:0]))
    else $error("primary divider upper bits wrong");
  a_secondary_low: assert property (
    wr_en && addr == ADDR_SEC_LO && !state_q.soft_rst
    |=> state_q.stage.sec_div[7:0] == $past(wdata))
    else $error("secondary divider low byte wrong");
  a_soft_reset_mirror: assert property (
    wr_en && addr == ADDR_SERIAL_CFG && (wdata[BIT_SRST_A] || wdata[BIT_SRST_B])
    && !state_q.soft_rst |=> soft_reset ##1 !soft_reset && customer_version == RST_VERSION)
    else $error("soft reset did not restore defaults");
  a_i2c_cfg_ignored: assert property (
    wr_en && addr == ADDR_SERIAL_CFG && i2c_mode && !state_q.soft_rst
    |=> $stable(lsb_first) && $stable(sdo_active))
    else $error("bit order or output enable changed in I2C mode");
  a_order_mirror: assert property (
    wr_en && addr == ADDR_SERIAL_CFG && !i2c_mode && !state_q.soft_rst
    |=> lsb_first == ($past(wdata[BIT_LSB_A]) | $past(wdata[BIT_LSB_B])))
    else $error("bit order mirror wrong");
  // Requests that land in the soft reset cycle are dropped, so every check but a_soft_reset_pulse skips it
  a_unmapped_read: assert property (
    rd_en && !addr_hit && !state_q.soft_rst |=> rd_valid && rdata == READ_UNMAPPED)
    else $error("unmapped read returned nonzero data");
  a_readback_reserved: assert property (
    rd_en && addr == ADDR_READBACK && !state_q.soft_rst |=> rdata[7:1] == 7'h00)
    else $error("readback control reserved bits not zero");
  a_version_low: assert property (
    wr_en && addr == ADDR_VER_LO && !state_q.soft_rst
    |=> state_q.stage.version[7:0] == $past(wdata))
    else $error("customer version low byte wrong");
  a_update_copies: assert property (
    io_update && !state_q.soft_rst |=> {customer_version, primary_reference_div,
    secondary_reference_div, test_ref_div} == $past(state_q.stage))
    else $error("update did not copy staged settings");
  a_outputs_hold: assert property (
    !io_update && !state_q.soft_rst |=> $stable({customer_version, primary_reference_div,
    secondary_reference_div, test_ref_div}))
    else $error("active settings changed without update");
  a_primary_low: assert property (
    wr_en && addr == ADDR_PRI_LO && !state_q.soft_rst
    |=> state_q.stage.pri_div[7:0] == $past(wdata))
    else $error("primary divider low byte wrong");
  a_divider_reserved: assert property (
    rd_en && (addr == ADDR_PRI_HI || addr == ADDR_SEC_HI) && !state_q.soft_rst
    |=> rdata[7:2] == 6'h00)
    else $error("divider upper byte reserved bits not zero");
  a_secondary_high: assert property (
    wr_en && addr == ADDR_SEC_HI && !state_q.soft_rst
    |=> state_q.stage.sec_div[9:8] == $past(wdata[1:0]))
    else $error("secondary divider upper bits wrong");
  a_sdo_mirror: assert property (
    wr_en && addr == ADDR_SERIAL_CFG && !i2c_mode && !state_q.soft_rst
    |=> sdo_active == ($past(wdata[BIT_SDO_A]) | $past(wdata[BIT_SDO_B])))
    else $error("output enable mirror wrong");
  a_cfg_read_mirror: assert property (
    rd_en && addr == ADDR_SERIAL_CFG && !state_q.soft_rst
    |=> rdata[BIT_SDO_A] == rdata[BIT_SDO_B] && rdata[BIT_LSB_A] == rdata[BIT_LSB_B]
    && rdata[BIT_SRST_A:BIT_SRST_B] == 4'h0)
    else $error("configuration read mirror wrong");
  a_soft_reset_pulse: assert property (
    soft_reset |=> !soft_reset && !sdo_active && !lsb_first && !state_q.readback
    && state_q.stage == SET_RESET)
    else $error("soft reset left settings behind");

  c_soft_reset: cover property (wr_en && addr == ADDR_SERIAL_CFG ##1 soft_reset);
  c_update_then_read: cover property (io_update ##1 rd_en && state_q.readback);
  c_unmapped: cover property (wr_en && !addr_hit);
  c_i2c_config: cover property (wr_en && addr == ADDR_SERIAL_CFG && i2c_mode);
  c_active_read: cover property (rd_en && addr == ADDR_PRI_LO && state_q.readback);

endmodule

// ### ccr_host.sv
`timescale 1ns/1ps
module ccr_host
  import ccr_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic [7:0] rdata, // Read data from the bank
  input wire logic rd_valid, // Read answer strobe
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [ADDR_W-1:0] addr, // Register address
  output logic [7:0] wdata, // Write data
  output logic io_update // Staged to active copy strobe
);
  initial begin
    {wr_en, rd_en, io_update, addr, wdata} = '0;
  end
  // Reserved positions are always sent as their zero defaults
  function automatic logic [7:0] msk(input logic [11:0] a);
    case (a)
      ADDR_SERIAL_CFG: msk = 8'hE7;
      ADDR_READBACK: msk = 8'h01;
      ADDR_PRI_HI, ADDR_SEC_HI: msk = 8'h03;
      ADDR_TEST_DIV: msk = 8'h3F;
      default: msk = 8'hFF;
    endcase
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d & msk(a);
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~wdata;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    d = rd_valid ? rdata : 8'hXX;
  endtask
  task automatic upd();
    @(negedge clk);
    io_update = 1'b1;
    @(negedge clk);
    io_update = 1'b0;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ccr_pkg::*;
;
  logic clk, srst, i2c_mode, wr_en, rd_en, io_update, rd_valid;
  logic soft_reset, sdo_active, lsb_first;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] customer_version;
  logic [9:0] primary_reference_div, secondary_reference_div;
  logic [5:0] test_ref_div;
  logic [7:0] stg [logic [11:0]];
  logic [7:0] act [logic [11:0]];
  logic [11:0] amap [9] = '{ADDR_SERIAL_CFG, ADDR_READBACK, ADDR_VER_LO, ADDR_VER_HI,
    ADDR_PRI_LO, ADDR_PRI_HI, ADDR_SEC_LO, ADDR_SEC_HI, ADDR_TEST_DIV};
  logic [11:0] umap [4] = '{12'h001, 12'h007, 12'h00F, 12'hFFF};
  int err_total = 0;
  int check_count = 0;
  ccr_host host (.clk(clk), .rdata(rdata), .rd_valid(rd_valid), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .io_update(io_update));
  ccr_regs uut (.clk(clk), .srst(srst), .i2c_mode(i2c_mode), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .io_update(io_update), .rdata(rdata), .rd_valid(rd_valid),
    .soft_reset(soft_reset), .sdo_active(sdo_active), .lsb_first(lsb_first),
    .customer_version(customer_version), .primary_reference_div(primary_reference_div),
    .secondary_reference_div(secondary_reference_div), .test_ref_div(test_ref_div));
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ochk();
    chk(customer_version, {act[ADDR_VER_HI], act[ADDR_VER_LO]});
    chk(primary_reference_div, {act[ADDR_PRI_HI][1:0], act[ADDR_PRI_LO]});
    chk(secondary_reference_div, {act[ADDR_SEC_HI][1:0], act[ADDR_SEC_LO]});
    chk(test_ref_div, act[ADDR_TEST_DIV][5:0]);
  endtask
  task automatic rchk(input logic [11:0] a);
    logic [7:0] d, e;
    e = 8'h00;
    if (stg.exists(a)) e = (stg[ADDR_READBACK][0] && a > 12'h004) ? act[a] : stg[a];
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic wr_rand();
    logic [31:0] v;
    for (int k = 2; k < 9; k++) begin
      v = $urandom;
      host.wr(amap[k], v[7:0]);
      stg[amap[k]] = v[7:0] & host.msk(amap[k]);
    end
  endtask
  task automatic sreset(input logic [7:0] v);
    host.wr(ADDR_SERIAL_CFG, v);
    chk(soft_reset, 1'b1);
    foreach (amap[i]) stg[amap[i]] = 8'h00;
    act = stg;
    @(negedge clk);
    chk({soft_reset, sdo_active, lsb_first}, 3'b000);
    ochk();
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [31:0] v;
    srst = 1'b1;
    i2c_mode = 1'b0;
    v = $urandom(32'hA3F4C5D5);
    foreach (amap[i]) stg[amap[i]] = 8'h00;
    act = stg;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    foreach (amap[i]) rchk(amap[i]);
    wr_rand();
    foreach (amap[i]) rchk(amap[i]);
    ochk();
    v = $urandom;
    host.wr(ADDR_VER_HI, v[7:0]);
    stg[ADDR_VER_HI] = v[7:0];
    host.upd();
    act = stg;
    ochk();
    host.wr(ADDR_READBACK, 8'hFF);
    stg[ADDR_READBACK] = 8'h01;
    rchk(ADDR_READBACK);
    wr_rand();
    foreach (amap[i]) rchk(amap[i]);
    host.upd();
    act = stg;
    foreach (umap[i]) begin
      v = $urandom;
      host.wr(umap[i], v[7:0]);
      rchk(umap[i]);
    end
    foreach (amap[i]) rchk(amap[i]);
    ochk();
    host.wr(ADDR_SERIAL_CFG, 8'h80);
    stg[ADDR_SERIAL_CFG] = 8'h81;
    rchk(ADDR_SERIAL_CFG);
    chk({sdo_active, lsb_first}, 2'b10);
    host.wr(ADDR_SERIAL_CFG, 8'h02);
    stg[ADDR_SERIAL_CFG] = 8'h42;
    i2c_mode = 1'b1;
    host.wr(ADDR_SERIAL_CFG, 8'h00);
    rchk(ADDR_SERIAL_CFG);
    chk({sdo_active, lsb_first}, 2'b01);
    sreset(8'h20);
    i2c_mode = 1'b0;
    wr_rand();
    host.upd();
    sreset(8'h04);
    foreach (amap[i]) rchk(amap[i]);
    stop_test();
  end
endmodule
